// ===== bench/host_model.sv
/* Bus engine model giving link events one at a time.
   Assumes the bank answers by dropping link_busy. */
module host_model (
    input  wire logic       link_clk,
    output logic            rd_start,
    output logic            byte_req,
    output logic            stop_seen,
    output logic            index_write,
    output logic [7:0]      index_value,
    output logic            data_write,
    output logic [7:0]      data_value,
    input  wire logic       link_busy
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {rd_start, byte_req, stop_seen, index_write, data_write} = '0;
        index_value = 8'h00;
        data_value = 8'h00;
    end

    // kind 0 index, 1 start, 2 byte, 3 write, else stop
    task automatic ev(input int kind, input logic [7:0] v, input int slow);
        int n = 0;
        repeat (slow) @(negedge link_clk);
        @(negedge link_clk);
        case (kind)
            0: begin
                index_write = 1'b1;
                index_value = v;
            end
            1: rd_start = 1'b1;
            2: byte_req = 1'b1;
            3: begin
                data_write = 1'b1;
                data_value = v;
            end
            default: stop_seen = 1'b1;
        endcase
        @(negedge link_clk);
        {rd_start, byte_req, stop_seen, index_write, data_write} = '0;
        // released value lines show no stale data
        index_value = ~index_value;
        data_value = ~data_value;
        while (link_busy && n < 40) begin
            @(negedge link_clk);
            n++;
        end
    endtask : ev
endmodule : host_model

// ===== bench/result_bank_status_flags_chk.sv
/* Assertions on the result bank top ports.
   Bound from the bench; needs both clocks and arst_n. */
module result_bank_status_flags_chk (
    input wire logic       clk_sys,
    input wire logic       arst_n,
    input wire logic       link_clk,
    input wire logic       link_busy,
    input wire logic       byte_valid,
    input wire logic [7:0] byte_out,
    input wire logic       meas_state,
    input wire logic       sw_reset,
    input wire logic       measuring,
    input wire logic [7:0] state_control,
    input wire logic       ready
);
    timeunit 1ns;
    timeprecision 1ps;

    AST_READY_INV: assert property (
        @(posedge clk_sys) disable iff (!arst_n) ready == !measuring)
        else $error("ready not inverse of measuring");
    AST_SW_CLEAR: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        sw_reset |=> state_control == 8'h00)
        else $error("state_control kept after software reset");
    AST_CTRL_CAUSE: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        $changed(state_control) |-> $past(sw_reset) || $past(link_busy))
        else $error("state_control changed without a command");
    AST_BV_PULSE: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        byte_valid |=> !byte_valid)
        else $error("byte_valid longer than one cycle");
    AST_BV_CAUSE: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        byte_valid |-> $past(link_busy) && !link_busy)
        else $error("read byte without pending request");
    AST_BUSY_BOUND: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        $rose(link_busy) |-> ##[1:16] !link_busy)
        else $error("bank answer too late");
    AST_OUT_HOLD: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        !byte_valid |-> $stable(byte_out))
        else $error("byte_out moved without byte_valid");
    AST_CFG_ZERO: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        byte_valid && !meas_state |-> byte_out == 8'h00)
        else $error("data read outside measurement state");

    COV_READ: cover property (@(posedge link_clk) byte_valid);
    COV_CFG: cover property (@(posedge link_clk) byte_valid && !meas_state);
    COV_SWR: cover property (@(posedge clk_sys) sw_reset);
endmodule : result_bank_status_flags_chk

// ===== bench/test_result_bank_status_flags.sv
/* Bench for the result bank: host model on the link, measurement
   engine and byte scoreboard here. Needs the design package. */
module test_result_bank_status_flags
    import result_bank_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, link_clk, arst_n, link_busy, byte_valid;
    logic        rd_start, byte_req, stop_seen, index_write, data_write;
    logic [7:0]  index_value, data_value, byte_out, state_control, sc;
    logic        meas_state, sw_reset, meas_done, time_wrapped, ready;
    logic        converter_overdrive, measuring, standby_int;
    logic        power_down_int, sync_start_stop_mode, time_ref_enable;
    logic [11:0] thermal_count;
    logic [16:0] x_count, y_count, z_count;
    logic [23:0] time_count;
    logic [15:0] lfsr, r[1:6], bf[1:6];
    logic [2:0]  rf, bff;
    logic        f_new, f_lost, pend, frz;
    logic [7:0]  exp_q[$];
    int          n_mismatch, total_checks, cyc;

    result_bank_status_flags dut (.*);
    host_model host (.*);

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #24 link_clk = ~link_clk;
    end

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt

    task automatic check(input string w, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", w, exp, seen);
        end
    endtask : check

    task automatic final_report;
        check("pending bytes", 8'(exp_q.size()), 8'h00);
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    task automatic clear_bank;
        r = '{default: RESULT_RST};
        bf = '{default: RESULT_RST};
        {rf, bff, f_new, f_lost, pend} = '0;
    endtask : clear_bank

    task automatic meas(input logic [16:0] x, input logic [1:0] wo);
        @(negedge clk_sys);
        x_count = x;
        y_count = {1'b0, lfsr};
        z_count = {1'b0, ~lfsr};
        thermal_count = lfsr[11:0];
        time_count = {lfsr[7:0], ~lfsr};
        {time_wrapped, converter_overdrive} = wo;
        meas_done = 1'b1;
        bf[1] = {THERMAL_PAD, thermal_count};
        if (sync_start_stop_mode && (!time_ref_enable ||
            time_count < THERMAL_MIN_CLOCKS)) bf[1] = RESULT_RST;
        bf[2] = x[16] ? RESULT_SAT : x[15:0];
        bf[3] = y_count[15:0];
        bf[4] = z_count[15:0];
        bf[5] = time_count[15:0];
        bf[6] = {EMPTY_BYTE, time_count[23:16]};
        bff = {wo[1] & sync_start_stop_mode & time_ref_enable,
               x[16], wo[0]};
        f_lost = f_lost | pend;
        f_new = 1'b1;
        pend = 1'b1;
        @(negedge clk_sys);
        meas_done = 1'b0;
        lfsr = nxt(lfsr);
    endtask : meas

    // n bytes from index a; a measurement lands before byte mid
    task automatic rd(input logic [7:0] a, input int n, input int mid);
        logic [7:0] i;
        logic [7:0] e;
        logic       h;
        i = a;
        h = 1'b0;
        host.ev(0, a, 0);
        if (meas_state && !frz) begin
            r = bf;
            rf = bff;
            pend = 1'b0;
        end
        frz = 1'b1;
        host.ev(1, 8'h00, 1);
        for (int k = 0; k < n; k++) begin
            if (k == mid) meas({1'b0, ~lfsr}, 2'b00);
            e = 8'h00;
            if (meas_state && i == 8'h00)
                e = h ? {rf, f_lost, f_new, measuring, standby_int,
                         power_down_int} : sc;
            else if (meas_state && i <= 8'h06)
                e = h ? r[i][15:8] : r[i][7:0];
            if (meas_state && i == 8'h00 && h)
                {f_new, f_lost} = 2'b00;
            if (meas_state && i >= 8'h02 && i <= 8'h04)
                f_new = 1'b0;
            exp_q.push_back(e);
            host.ev(2, 8'h00, k % 3);
            if (h) i = i + 8'h01;
            h = ~h;
        end
        host.ev(4, 8'h00, 0);
        frz = 1'b0;
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host.ev(0, a, 0);
        host.ev(3, v, 2);
        if (a == 8'h00) sc = v;
        check("state_control", state_control, sc);
    endtask : wr

    always @(negedge link_clk) begin
        if (byte_valid === 1'b1 && exp_q.size() > 0)
            check("read byte", byte_out, exp_q.pop_front());
        else if (byte_valid === 1'b1)
            check("spare byte", 8'h01, 8'h00);
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        {arst_n, sw_reset, meas_done, time_wrapped} = '0;
        {converter_overdrive, measuring, standby_int, power_down_int} = '0;
        {sync_start_stop_mode, time_ref_enable} = '0;
        {thermal_count, x_count, y_count, z_count, time_count} = '0;
        meas_state = 1'b1;
        lfsr = 16'h3302;
        sc = STATE_CONTROL_RST;
        frz = 1'b0;
        clear_bank();
        repeat (4) @(negedge clk_sys);
        arst_n = 1'b1;
        check("state_control", state_control, sc);
        wr(8'h00, lfsr[7:0]);
        wr(8'h02, 8'h5a);
        rd(8'h00, 2, -1);
        $display("write test done");
        meas({1'b0, lfsr}, 2'b00);
        rd(8'h00, 14, -1);
        rd(8'h00, 2, -1);
        $display("full read test done");
        meas({1'b0, lfsr}, 2'b00);
        meas({1'b0, lfsr}, 2'b00);
        rd(8'h02, 2, -1);
        rd(8'h00, 2, -1);
        rd(8'h00, 2, -1);
        $display("lost data test done");
        meas({1'b0, lfsr}, 2'b00);
        rd(8'h02, 6, 2);
        rd(8'h02, 6, -1);
        $display("freeze test done");
        for (int k = 0; k < 4; k++) begin
            @(negedge clk_sys);
            {sync_start_stop_mode, time_ref_enable} = k[1:0];
            {measuring, standby_int, power_down_int} = lfsr[2:0];
            meas(17'h1_0000, 2'b11);
            check("ready", {7'h00, ready}, {7'h00, ~measuring});
            rd(8'h00, 14, -1);
        end
        $display("flag test done");
        @(negedge clk_sys);
        meas_state = 1'b0;
        clear_bank();
        repeat (4) @(negedge clk_sys);
        rd(8'h02, 2, -1);
        @(negedge clk_sys);
        meas_state = 1'b1;
        rd(8'h00, 6, -1);
        $display("configuration test done");
        meas({1'b0, lfsr}, 2'b00);
        @(negedge clk_sys);
        sw_reset = 1'b1;
        @(negedge clk_sys);
        sw_reset = 1'b0;
        sc = STATE_CONTROL_RST;
        clear_bank();
        check("state_control", state_control, sc);
        rd(8'h00, 6, -1);
        $display("software reset test done");
        final_report();
    end
endmodule : test_result_bank_status_flags

bind result_bank_status_flags result_bank_status_flags_chk chk (.*);

// ===== verilog/bank_link_if.sv
/*
 * Carrier between the link-side byte server and the register bank.
 * A toggle on req_toggle hands over op, addr, byte_hi and wdata; a toggle
 * on ack_toggle hands back rdata. Payload stays still until the answer.
 */
interface bank_link_if;
    import result_bank_pkg::*;

    logic       req_toggle;
    link_op_e   op;
    logic [7:0] addr;
    logic       byte_hi;
    logic [7:0] wdata;
    logic       ack_toggle;
    logic [7:0] rdata;

    modport link (
        output req_toggle,
        output op,
        output addr,
        output byte_hi,
        output wdata,
        input  ack_toggle,
        input  rdata
    );

    modport bank (
        input  req_toggle,
        input  op,
        input  addr,
        input  byte_hi,
        input  wdata,
        output ack_toggle,
        output rdata
    );
endinterface : bank_link_if

// ===== verilog/byte_link_server.sv
/*
 * Link-clock side of the register bank. Turns the byte events of the bus
 * engine into commands for the bank, keeps the register index and the
 * byte order, and returns read bytes.
 * Assumes a bus engine on link_clk that gives one-cycle event pulses and
 * holds off further events while link_busy is high.
 */
module byte_link_server
    import result_bank_pkg::*;
(
    input  wire logic   link_clk,
    input  wire logic   arst_n,
    input  wire logic   rd_start,
    input  wire logic   byte_req,
    input  wire logic   stop_seen,
    input  wire logic   index_write,
    input  wire logic [7:0] index_value,
    input  wire logic   data_write,
    input  wire logic [7:0] data_value,
    output logic        link_busy,
    output logic        byte_valid,
    output logic [7:0]  byte_out,
    bank_link_if.link   bank
);
    typedef enum logic [1:0] {
        LS_IDLE = 2'b01,
        LS_WAIT = 2'b10
    } link_state_e;

    typedef struct packed {
        link_state_e state;
        logic [7:0]  index;
        logic        byte_hi;
        logic        req_toggle;
        link_op_e    op;
        logic [7:0]  addr;
        logic        sel_hi;
        logic [7:0]  wdata;
        logic        ack_s1;
        logic        ack_s2;
        logic        ack_seen;
        logic        byte_valid;
        logic [7:0]  byte_out;
    } link_s;

    link_s link_reg;
    link_s link_next;

    always_comb begin
        link_next = link_reg;
        link_next.ack_s1 = bank.ack_toggle;
        link_next.ack_s2 = link_reg.ack_s1;
        link_next.byte_valid = 1'b0;
        case (link_reg.state)
            LS_IDLE: begin
                if (index_write) begin
                    link_next.index = index_value;
                    link_next.byte_hi = 1'b0;
                end else if (rd_start || byte_req || data_write
                             || stop_seen) begin
                    link_next.op = rd_start   ? OP_START :
                                   byte_req   ? OP_READ  :
                                   data_write ? OP_WRITE : OP_STOP;
                    link_next.addr = link_reg.index;
                    link_next.sel_hi = link_reg.byte_hi;
                    link_next.wdata = data_value;
                    link_next.req_toggle = ~link_reg.req_toggle;
                    link_next.state = LS_WAIT;
                    if (!rd_start && (byte_req || data_write)) begin
                        link_next.byte_hi = ~link_reg.byte_hi;
                        if (link_reg.byte_hi) begin
                            link_next.index = link_reg.index + 8'h01;
                        end
                    end
                end
            end
            LS_WAIT: begin
                if (link_reg.ack_s2 != link_reg.ack_seen) begin
                    link_next.ack_seen = link_reg.ack_s2;
                    link_next.state = LS_IDLE;
                    if (link_reg.op == OP_READ) begin
                        link_next.byte_valid = 1'b1;
                        link_next.byte_out = bank.rdata;
                    end
                end
            end
            default: link_next.state = LS_IDLE;
        endcase
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            link_reg <= '{state: LS_IDLE, op: OP_STOP, default: '0};
        end else begin
            link_reg <= link_next;
        end
    end

    assign link_busy    = (link_reg.state == LS_WAIT);
    assign byte_valid   = link_reg.byte_valid;
    assign byte_out     = link_reg.byte_out;
    assign bank.req_toggle = link_reg.req_toggle;
    assign bank.op      = link_reg.op;
    assign bank.addr    = link_reg.addr;
    assign bank.byte_hi = link_reg.sel_hi;
    assign bank.wdata   = link_reg.wdata;

endmodule : byte_link_server

// ===== verilog/result_bank_pkg.sv
/*
 * Constants for the result register bank: register indexes, status bit
 * positions, reset values and the command codes that cross from the
 * link domain to the system domain.
 * Assumes nothing of its surroundings.
 */
package result_bank_pkg;

    // register indexes on the link
    localparam logic [7:0] ADDR_STATE_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS_FLAGS  = 8'h00;
    localparam logic [7:0] ADDR_THERMAL       = 8'h01;
    localparam logic [7:0] ADDR_X_CHANNEL     = 8'h02;
    localparam logic [7:0] ADDR_Y_CHANNEL     = 8'h03;
    localparam logic [7:0] ADDR_Z_CHANNEL     = 8'h04;
    localparam logic [7:0] ADDR_TIME_REF_LOW  = 8'h05;
    localparam logic [7:0] ADDR_TIME_REF_HIGH = 8'h06;

    // status_flags bit positions
    localparam int STAT_TIME_OVF  = 7;
    localparam int STAT_RES_OVF   = 6;
    localparam int STAT_CONV_OVR  = 5;
    localparam int STAT_LOST      = 4;
    localparam int STAT_NEW       = 3;
    localparam int STAT_MEASURING = 2;
    localparam int STAT_STANDBY   = 1;
    localparam int STAT_PWR_DOWN  = 0;

    // widths and reset values
    localparam int RESULT_W    = 16;
    localparam int THERMAL_W   = 12;
    localparam int TIME_REF_W  = 24;
    localparam logic [7:0]  STATE_CONTROL_RST = 8'h00;
    localparam logic [15:0] RESULT_RST        = 16'h0000;
    localparam logic [15:0] RESULT_SAT        = 16'hFFFF;
    localparam logic [7:0]  EMPTY_BYTE        = 8'h00;
    localparam logic [3:0]  THERMAL_PAD       = 4'h0;

    // least conversion time for a valid thermal result, in system clocks
    localparam logic [23:0] THERMAL_MIN_CLOCKS = 24'h00_1000;

    typedef enum logic [3:0] {
        OP_START = 4'b0001,
        OP_READ  = 4'b0010,
        OP_WRITE = 4'b0100,
        OP_STOP  = 4'b1000
    } link_op_e;

endpackage : result_bank_pkg

// ===== verilog/result_bank_status_flags.sv
/*
 * Output result register bank of a colour sensor: state_control byte,
 * status_flags byte, thermal result, three channel results and the 24-bit
 * conversion time reference, with buffering, transfer and flag logic.
 * Assumes a measurement engine on clk_sys and a bus engine on link_clk
 * giving byte events; link commands cross by toggle handshake.
 */
module result_bank_status_flags
    import result_bank_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // bus engine side, link clock domain
    input  wire logic        link_clk,
    input  wire logic        rd_start,
    input  wire logic        byte_req,
    input  wire logic        stop_seen,
    input  wire logic        index_write,
    input  wire logic [7:0]  index_value,
    input  wire logic        data_write,
    input  wire logic [7:0]  data_value,
    output logic             link_busy,
    output logic             byte_valid,
    output logic [7:0]       byte_out,
    // measurement engine side, system clock domain
    input  wire logic        meas_state,
    input  wire logic        sw_reset,
    input  wire logic        meas_done,
    input  wire logic [11:0] thermal_count,
    input  wire logic [16:0] x_count,
    input  wire logic [16:0] y_count,
    input  wire logic [16:0] z_count,
    input  wire logic [23:0] time_count,
    input  wire logic        time_wrapped,
    input  wire logic        converter_overdrive,
    input  wire logic        measuring,
    input  wire logic        standby_int,
    input  wire logic        power_down_int,
    input  wire logic        sync_start_stop_mode,
    input  wire logic        time_ref_enable,
    output logic [7:0]       state_control,
    output logic             ready
);
    typedef struct packed {
        logic [7:0]  state_ctl;
        logic        req_s1;
        logic        req_s2;
        logic        req_seen;
        logic        ack_toggle;
        logic [7:0]  rdata;
        logic [11:0] buf_thermal;
        logic [15:0] buf_x;
        logic [15:0] buf_y;
        logic [15:0] buf_z;
        logic [23:0] buf_time;
        logic [2:0]  buf_ovf;
        logic        buf_fresh;
        logic [11:0] res_thermal;
        logic [15:0] res_x;
        logic [15:0] res_y;
        logic [15:0] res_z;
        logic [23:0] res_time;
        logic [2:0]  res_ovf;
        logic        new_flag;
        logic        lost_flag;
        logic        frozen;
    } bank_s;

    bank_s bank_reg;
    bank_s bank_next;

    bank_link_if link_bus ();

    byte_link_server u_link (
        .link_clk    (link_clk),
        .arst_n      (arst_n),
        .rd_start    (rd_start),
        .byte_req    (byte_req),
        .stop_seen   (stop_seen),
        .index_write (index_write),
        .index_value (index_value),
        .data_write  (data_write),
        .data_value  (data_value),
        .link_busy   (link_busy),
        .byte_valid  (byte_valid),
        .byte_out    (byte_out),
        .bank        (link_bus.link)
    );

    // conditioning of engine results
    logic        time_ref_used;
    logic [15:0] sat_x;
    logic [15:0] sat_y;
    logic [15:0] sat_z;
    logic        chan_ovf;
    logic        thermal_ok;
    logic [11:0] thermal_keep;

    assign time_ref_used = sync_start_stop_mode && time_ref_enable;
    assign sat_x = x_count[16] ? RESULT_SAT : x_count[15:0];
    assign sat_y = y_count[16] ? RESULT_SAT : y_count[15:0];
    assign sat_z = z_count[16] ? RESULT_SAT : z_count[15:0];
    assign chan_ovf = x_count[16] || y_count[16] || z_count[16];
    // sync mode needs the time reference and a long enough conversion
    assign thermal_ok = !sync_start_stop_mode
                        || (time_ref_enable
                            && time_count >= THERMAL_MIN_CLOCKS);
    assign thermal_keep = thermal_ok ? thermal_count : '0;

    // status byte as seen by the bus
    logic [7:0] status_byte;

    always_comb begin
        status_byte = '0;
        status_byte[STAT_TIME_OVF]  = bank_reg.res_ovf[2];
        status_byte[STAT_RES_OVF]   = bank_reg.res_ovf[1];
        status_byte[STAT_CONV_OVR]  = bank_reg.res_ovf[0];
        status_byte[STAT_LOST]      = bank_reg.lost_flag;
        status_byte[STAT_NEW]       = bank_reg.new_flag;
        status_byte[STAT_MEASURING] = measuring;
        status_byte[STAT_STANDBY]   = standby_int;
        status_byte[STAT_PWR_DOWN]  = power_down_int;
    end

    // word held at a register index, low byte first on the bus
    logic [15:0] read_word;

    always_comb begin
        case (link_bus.addr)
            ADDR_STATE_CONTROL: read_word = {status_byte,
                                             bank_reg.state_ctl};
            ADDR_THERMAL:       read_word = {THERMAL_PAD,
                                             bank_reg.res_thermal};
            ADDR_X_CHANNEL:     read_word = bank_reg.res_x;
            ADDR_Y_CHANNEL:     read_word = bank_reg.res_y;
            ADDR_Z_CHANNEL:     read_word = bank_reg.res_z;
            ADDR_TIME_REF_LOW:  read_word = bank_reg.res_time[15:0];
            ADDR_TIME_REF_HIGH: read_word = {EMPTY_BYTE,
                                             bank_reg.res_time[23:16]};
            default:            read_word = RESULT_RST;
        endcase
    end

    // command decode from the link domain
    logic req_event;
    logic do_start;
    logic do_read;
    logic do_write;
    logic do_stop;
    logic read_status;
    logic read_channel;
    logic clear_bank;

    assign req_event = bank_reg.req_s2 ^ bank_reg.req_seen;
    assign do_start  = req_event && (link_bus.op == OP_START);
    assign do_read   = req_event && (link_bus.op == OP_READ)
                       && meas_state;
    assign do_write  = req_event && (link_bus.op == OP_WRITE);
    assign do_stop   = req_event && (link_bus.op == OP_STOP);
    assign read_status = do_read && link_bus.byte_hi
                         && (link_bus.addr == ADDR_STATUS_FLAGS);
    assign read_channel = do_read
                          && (link_bus.addr == ADDR_X_CHANNEL
                              || link_bus.addr == ADDR_Y_CHANNEL
                              || link_bus.addr == ADDR_Z_CHANNEL);
    assign clear_bank = sw_reset || !meas_state;

    always_comb begin
        bank_next = bank_reg;
        bank_next.req_s1 = link_bus.req_toggle;
        bank_next.req_s2 = bank_reg.req_s1;
        bank_next.req_seen = bank_reg.req_s2;

        // every command is answered, reads in the measurement state with data
        if (req_event) begin
            bank_next.ack_toggle = ~bank_reg.ack_toggle;
            bank_next.rdata = EMPTY_BYTE;
        end
        if (do_read) begin
            bank_next.rdata = link_bus.byte_hi ? read_word[15:8]
                                               : read_word[7:0];
        end

        // only the low byte at address 0 takes writes
        if (do_write && link_bus.addr == ADDR_STATE_CONTROL
            && !link_bus.byte_hi) begin
            bank_next.state_ctl = link_bus.wdata;
        end

        // clear requests first, so that a set in the same cycle wins
        if (read_status || read_channel) begin
            bank_next.new_flag = 1'b0;
        end
        if (read_status) begin
            bank_next.lost_flag = 1'b0;
        end

        // transfer at the start of a read, held until STOP
        if (do_start && meas_state && !bank_reg.frozen) begin
            bank_next.res_thermal = bank_reg.buf_thermal;
            bank_next.res_x = bank_reg.buf_x;
            bank_next.res_y = bank_reg.buf_y;
            bank_next.res_z = bank_reg.buf_z;
            bank_next.res_time = bank_reg.buf_time;
            bank_next.res_ovf = bank_reg.buf_ovf;
            bank_next.buf_fresh = 1'b0;
            bank_next.frozen = 1'b1;
        end
        if (do_stop) begin
            bank_next.frozen = 1'b0;
        end

        // end of a measurement cycle fills the buffers
        if (meas_done) begin
            bank_next.buf_thermal = thermal_keep;
            bank_next.buf_x = sat_x;
            bank_next.buf_y = sat_y;
            bank_next.buf_z = sat_z;
            bank_next.buf_time = time_count;
            bank_next.buf_ovf = {time_wrapped && time_ref_used,
                                 chan_ovf,
                                 converter_overdrive};
            if (bank_next.buf_fresh) begin
                bank_next.lost_flag = 1'b1;
            end
            bank_next.buf_fresh = 1'b1;
            bank_next.new_flag = 1'b1;
        end

        if (clear_bank) begin
            bank_next.buf_thermal = '0;
            bank_next.buf_x = RESULT_RST;
            bank_next.buf_y = RESULT_RST;
            bank_next.buf_z = RESULT_RST;
            bank_next.buf_time = '0;
            bank_next.buf_ovf = '0;
            bank_next.buf_fresh = 1'b0;
            bank_next.res_thermal = '0;
            bank_next.res_x = RESULT_RST;
            bank_next.res_y = RESULT_RST;
            bank_next.res_z = RESULT_RST;
            bank_next.res_time = '0;
            bank_next.res_ovf = '0;
            bank_next.new_flag = 1'b0;
            bank_next.lost_flag = 1'b0;
            bank_next.frozen = 1'b0;
        end
        if (sw_reset) begin
            bank_next.state_ctl = STATE_CONTROL_RST;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bank_reg <= '{state_ctl: STATE_CONTROL_RST, default: '0};
        end else begin
            bank_reg <= bank_next;
        end
    end

    assign link_bus.ack_toggle = bank_reg.ack_toggle;
    assign link_bus.rdata      = bank_reg.rdata;
    assign state_control       = bank_reg.state_ctl;
    assign ready               = !measuring;

endmodule : result_bank_status_flags
